// ===== mfc_cs_bank.sv
// Purpose: per-buffer control, configuration and status words
// Assumes: host write and flag set arrive on the same clock
// Notes: reserved bits stay zero; a flag set beats a host write
`timescale 1ns/10ps
`default_nettype none
module mfc_cs_bank
  import mfc_pkg::*;
#(
  parameter int unsigned NBUF = NUM_BUF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire mfc_wr_t wr,
  input wire logic flag_set,
  input wire logic [5:0] flag_idx,
  input wire logic [5:0] host_idx,
  input wire logic [5:0] core_idx,
  output logic [15:0] host_word,
  output var logic [15:0] core_word
);

  logic [15:0] word [NBUF];

  // one word per buffer
  for (genvar i = 0; i < NBUF; i++) begin : g_buf
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        word[i] <= WORD_RESET;
      end else begin
        if (wr.en && wr.idx == 6'(i)) begin
          word[i] <= mfc_merge(word[i], wr.data, wr.strb, CS_HOST_MASK);
        end
        if (flag_set && flag_idx == 6'(i)) begin
          word[i][CS_IRQ_FLAG_BIT] <= 1'b1;
        end
      end
    end
  end

  // host read port
  always_comb begin
    host_word = WORD_RESET;
    if (host_idx < 6'(NBUF)) begin
      host_word = word[host_idx];
    end
  end

  // core read port, one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_word <= WORD_RESET;
    end else if (core_idx < 6'(NBUF)) begin
      core_word <= word[core_idx];
    end else begin
      core_word <= WORD_RESET;
    end
  end

endmodule : mfc_cs_bank
`default_nettype wire

// ===== mfc_fifo_map.sv
// Purpose: turn the fifo size code into the number of fifo buffers
// Assumes: code sampled on the register clock
// Notes: codes past the top one saturate to the full set
`timescale 1ns/10ps
`default_nettype none
module mfc_fifo_map
  import mfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] size_code,
  output var logic [5:0] buf_count
);

  // fifo holds buffers 0 .. count-1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_count <= FIFO_SIZE_RESET;
    end else if (size_code > FIFO_MAX_CODE) begin
      buf_count <= FIFO_MAX_COUNT;
    end else begin
      buf_count <= size_code;
    end
  end

endmodule : mfc_fifo_map
`default_nettype wire

// ===== mfc_pkg.sv
// Purpose: shared constants, types and helpers of the buffer and FIFO config registers
// Assumes: register indices as printed; byte address is four times the index
// Notes: data words are 16 bits and sit in the low half of the 32-bit bus
package mfc_pkg;

  // register indices; byte address = 4 * index
  localparam logic [9:0] IDX_FIFO_SIZE = 10'h018;
  localparam logic [9:0] IDX_RX_FRAME_ID = 10'h140;
  localparam logic [9:0] IDX_TX_FRAME_ID = 10'h180;
  localparam logic [9:0] IDX_TX_CYC_LEN = 10'h182;
  localparam logic [9:0] IDX_TX_HCRC = 10'h184;
  localparam logic [9:0] IDX_TX_DATA_FIRST = 10'h186;
  localparam logic [9:0] IDX_TX_DATA_LAST = 10'h1A4;
  localparam logic [9:0] IDX_TX_SLOT_STATUS = 10'h1A6;
  localparam logic [9:0] IDX_BUF_CS_FIRST = 10'h200;
  localparam logic [9:0] IDX_BUF_CS_LAST = 10'h2E8;

  // buffer counts and fifo size encoding
  localparam int unsigned NUM_BUF = 59;
  localparam int unsigned NUM_TX_WORDS = 16;
  localparam logic [5:0] FIFO_MAX_CODE = 6'h3A;
  localparam logic [5:0] FIFO_MAX_COUNT = 6'h3B;
  localparam logic [5:0] FIFO_SIZE_RESET = 6'h00;

  // host-writable bit masks
  localparam logic [15:0] FIFO_HOST_MASK = 16'h003F;
  localparam logic [15:0] RX_FID_HOST_MASK = 16'h07FF;
  localparam logic [15:0] TX_FID_HOST_MASK = 16'hC7FF;
  localparam logic [15:0] TX_LEN_HOST_MASK = 16'h007F;
  localparam logic [15:0] TX_HCRC_HOST_MASK = 16'h07FF;
  localparam logic [15:0] TX_DATA_HOST_MASK = 16'hFFFF;
  localparam logic [15:0] CS_HOST_MASK = 16'hFF4D;

  // field positions
  localparam int unsigned CS_IRQ_FLAG_BIT = 2;
  localparam int unsigned RX_HW_FLAGS_LSB = 11;
  localparam int unsigned TX_CONFLICT_BIT = 0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [3:0] {
    REG_NONE, REG_FIFO_SIZE, REG_RX_FID, REG_TX_FID, REG_TX_CYC_LEN,
    REG_TX_HCRC, REG_TX_DATA, REG_TX_STATUS, REG_BUF_CS
  } mfc_reg_t;

  // one host write toward a word store
  typedef struct packed {
    logic en;
    logic [5:0] idx;
    logic [15:0] data;
    logic [1:0] strb;
  } mfc_wr_t;

  // header flags delivered by the receive path
  typedef struct packed {
    logic load;
    logic [4:0] flags;
  } mfc_rx_hdr_t;

  // byte-lane write merge limited to the host-writable bits
  function automatic logic [15:0] mfc_merge(input logic [15:0] old_word,
      input logic [15:0] new_word, input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old_word & ~lane) | (new_word & lane);
  endfunction : mfc_merge

endpackage : mfc_pkg

// ===== mfc_regs.sv
// Purpose: APB register bank for message buffer and receive fifo setup
// Assumes: core-side inputs share pclk; APB master follows the protocol
// Notes: zero-wait slave; unmapped addresses answer with pslverr
// Summary of operation
// - fifo is buffers from index 0 upward
// - fifo size writable only in configuration state
// - size n gives buffers 0..n-1
// - larger codes give buffers 0..58
// - 59 control words at base plus 4n
// - flag, enable, config, valid bits reset zero
// - transmit cycle-count bits never updated
// - sixteen payload words, even byte low
// - only conflict bit of transmit status updates
// - receive frame id host bits; flags hardware
`timescale 1ns/10ps
`default_nettype none
module mfc_regs
  import mfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic cfg_state,
  input wire mfc_rx_hdr_t rx_hdr,
  input wire logic tx_status_load,
  input wire logic tx_conflict,
  input wire logic flag_set,
  input wire logic [5:0] flag_idx,
  input wire logic [3:0] core_word_idx,
  input wire logic [5:0] core_buf_idx,
  output logic [5:0] fifo_buf_count,
  output var logic [15:0] tx_frame_id,
  output var logic [6:0] tx_payload_len,
  output var logic [10:0] tx_header_crc,
  output var logic [15:0] rx_frame_id,
  output var logic [15:0] core_word_data,
  output logic [15:0] core_buf_word,
  output var logic fifo_write_refused
);

  // decode an index into a register group
  function automatic mfc_reg_t mfc_decode(input logic [11:0] addr);
    logic [9:0] idx;
    mfc_reg_t r;
    idx = addr[11:2];
    r = REG_NONE;
    if (addr[1:0] != 2'b00) begin
      r = REG_NONE;
    end else if (idx == IDX_FIFO_SIZE) begin
      r = REG_FIFO_SIZE;
    end else if (idx == IDX_RX_FRAME_ID) begin
      r = REG_RX_FID;
    end else if (idx == IDX_TX_FRAME_ID) begin
      r = REG_TX_FID;
    end else if (idx == IDX_TX_CYC_LEN) begin
      r = REG_TX_CYC_LEN;
    end else if (idx == IDX_TX_HCRC) begin
      r = REG_TX_HCRC;
    end else if (idx >= IDX_TX_DATA_FIRST && idx <= IDX_TX_DATA_LAST
        && idx[0] == 1'b0) begin
      r = REG_TX_DATA;
    end else if (idx == IDX_TX_SLOT_STATUS) begin
      r = REG_TX_STATUS;
    end else if (idx >= IDX_BUF_CS_FIRST && idx <= IDX_BUF_CS_LAST
        && idx[1:0] == 2'b00) begin
      r = REG_BUF_CS;
    end
    return r;
  endfunction : mfc_decode

  logic [5:0] fifo_code;
  logic [15:0] tx_cyc_len;
  logic [15:0] tx_hcrc;
  logic [15:0] tx_data [NUM_TX_WORDS];
  logic transmit_conflict_bit;
  mfc_reg_t rd_sel;
  mfc_reg_t wr_sel;
  logic wr_go;
  logic wr_fifo;
  logic wr_rx_fid;
  logic wr_tx_fid;
  logic wr_tx_len;
  logic wr_tx_hcrc;
  logic wr_tx_data;
  logic wr_cs;
  logic [9:0] data_off;
  logic [9:0] cs_off;
  logic [3:0] data_word;
  logic [5:0] cs_idx;
  logic [15:0] wdata;
  logic [1:0] wstrb;
  logic [15:0] cs_host_word;
  logic [15:0] rd_word;
  mfc_wr_t cs_wr;

  // request decode; address is held by the master through the access phase
  assign rd_sel = mfc_decode(paddr);
  assign wr_sel = mfc_decode(paddr);
  assign wr_go = psel && penable && pready && pwrite;
  assign data_off = paddr[11:2] - IDX_TX_DATA_FIRST;
  assign cs_off = paddr[11:2] - IDX_BUF_CS_FIRST;
  assign data_word = data_off[4:1];
  assign cs_idx = cs_off[7:2];
  assign wdata = pwdata[15:0];
  assign wstrb = pstrb[1:0];

  // one write strobe per host-writable register group, raised only on the completing edge
  always_comb begin
    wr_fifo = 1'b0;
    wr_rx_fid = 1'b0;
    wr_tx_fid = 1'b0;
    wr_tx_len = 1'b0;
    wr_tx_hcrc = 1'b0;
    wr_tx_data = 1'b0;
    wr_cs = 1'b0;
    if (wr_go) begin
      case (wr_sel)
        REG_FIFO_SIZE: begin
          wr_fifo = 1'b1;
        end
        REG_RX_FID: begin
          wr_rx_fid = 1'b1;
        end
        REG_TX_FID: begin
          wr_tx_fid = 1'b1;
        end
        REG_TX_CYC_LEN: begin
          wr_tx_len = 1'b1;
        end
        REG_TX_HCRC: begin
          wr_tx_hcrc = 1'b1;
        end
        REG_TX_DATA: begin
          wr_tx_data = 1'b1;
        end
        REG_BUF_CS: begin
          wr_cs = 1'b1;
        end
        default: begin
          wr_cs = 1'b0; // status and unmapped writes go nowhere
        end
      endcase
    end
  end

  // access phase always completes in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // unmapped or misaligned addresses raise an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= (rd_sel == REG_NONE);
    end else begin
      pslverr <= 1'b0;
    end
  end

  // fifo size code; only taken in configuration state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_code <= FIFO_SIZE_RESET;
    end else if (wr_fifo && cfg_state) begin
      fifo_code <= 6'(mfc_merge({10'h000, fifo_code}, wdata, wstrb,
          FIFO_HOST_MASK));
    end
  end

  // flag a write dropped outside configuration state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_write_refused <= 1'b0;
    end else begin
      fifo_write_refused <= wr_fifo && !cfg_state;
    end
  end

  // saturating size to buffer count
  mfc_fifo_map u_fifo_map (
    .clk(pclk),
    .rst_n(presetn),
    .size_code(fifo_code),
    .buf_count(fifo_buf_count)
  );

  // receive frame id: host id bits, hardware header flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_frame_id <= WORD_RESET;
    end else begin
      if (wr_rx_fid) begin
        rx_frame_id <= mfc_merge(rx_frame_id, wdata, wstrb,
            RX_FID_HOST_MASK);
      end
      if (rx_hdr.load) begin
        rx_frame_id[RX_HW_FLAGS_LSB +: 5] <= rx_hdr.flags;
      end
    end
  end

  // transmit frame id; indicator bits 13..11 stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_frame_id <= WORD_RESET;
    end else if (wr_tx_fid) begin
      tx_frame_id <= mfc_merge(tx_frame_id, wdata, wstrb, TX_FID_HOST_MASK);
    end
  end

  // transmit length; cycle-count bits are never written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cyc_len <= WORD_RESET;
    end else if (wr_tx_len) begin
      tx_cyc_len <= mfc_merge(tx_cyc_len, wdata, wstrb, TX_LEN_HOST_MASK);
    end
  end

  assign tx_payload_len = tx_cyc_len[6:0];

  // transmit header crc
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hcrc <= WORD_RESET;
    end else if (wr_tx_hcrc) begin
      tx_hcrc <= mfc_merge(tx_hcrc, wdata, wstrb, TX_HCRC_HOST_MASK);
    end
  end

  assign tx_header_crc = tx_hcrc[10:0];

  // payload words: byte 2n low, byte 2n+1 high
  for (genvar w = 0; w < NUM_TX_WORDS; w++) begin : g_txd
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_data[w] <= WORD_RESET;
      end else if (wr_tx_data && data_word == 4'(w)) begin
        tx_data[w] <= mfc_merge(tx_data[w], wdata, wstrb,
            TX_DATA_HOST_MASK);
      end
    end
  end

  // core reads payload one cycle after asking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_word_data <= WORD_RESET;
    end else begin
      core_word_data <= tx_data[core_word_idx];
    end
  end

  // conflict bit follows the transmit path only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_conflict_bit <= 1'b0;
    end else if (tx_status_load) begin
      transmit_conflict_bit <= tx_conflict;
    end
  end

  // control word writes toward the bank
  always_comb begin
    cs_wr = '0;
    cs_wr.en = wr_cs;
    cs_wr.idx = cs_idx;
    cs_wr.data = wdata;
    cs_wr.strb = wstrb;
  end

  // per-buffer control and status storage
  mfc_cs_bank #(
    .NBUF(NUM_BUF)
  ) u_cs_bank (
    .clk(pclk),
    .rst_n(presetn),
    .wr(cs_wr),
    .flag_set(flag_set),
    .flag_idx(flag_idx),
    .host_idx(cs_idx),
    .core_idx(core_buf_idx),
    .host_word(cs_host_word),
    .core_word(core_buf_word)
  );

  // read word by group; status bits other than the conflict bit read zero
  always_comb begin
    rd_word = WORD_RESET;
    case (rd_sel)
      REG_FIFO_SIZE: begin
        rd_word = {10'h000, fifo_code};
      end
      REG_RX_FID: begin
        rd_word = rx_frame_id;
      end
      REG_TX_FID: begin
        rd_word = tx_frame_id;
      end
      REG_TX_CYC_LEN: begin
        rd_word = tx_cyc_len;
      end
      REG_TX_HCRC: begin
        rd_word = tx_hcrc;
      end
      REG_TX_DATA: begin
        rd_word = tx_data[data_word];
      end
      REG_TX_STATUS: begin
        rd_word = WORD_RESET;
        rd_word[TX_CONFLICT_BIT] = transmit_conflict_bit;
      end
      REG_BUF_CS: begin
        rd_word = cs_host_word;
      end
      default: begin
        rd_word = WORD_RESET;
      end
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd_word};
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
    end
  end

endmodule : mfc_regs
`default_nettype wire

// ===== mfc_regs_checker.sv
// Purpose: port-level checks of the buffer and fifo config register bank
// Assumes: zero-wait APB slave on pclk
// Notes: bound into mfc_regs
`timescale 1ns/10ps
`default_nettype none
module mfc_regs_checker
  import mfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cfg_state,
  input wire mfc_rx_hdr_t rx_hdr,
  input wire logic [5:0] core_buf_idx,
  input wire logic [15:0] core_buf_word,
  input wire logic [15:0] rx_frame_id,
  input wire logic [5:0] fifo_buf_count,
  input wire logic fifo_write_refused
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic fw;
  // fifo size write completing this edge
  assign fw = psel && penable && pready && pwrite && (paddr == 12'h060);
  function automatic logic [5:0] fmap(input logic [5:0] c);
    return (c > 6'h3A) ? 6'h3B : c;
  endfunction : fmap
  // bus handshake
  chk_ready_follows: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  chk_rdata_upper: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data set");
  chk_err_in_ready: assert property (pslverr |-> pready) else $error("stray slave error");
  // fifo size handling
  chk_fifo_apply: assert property (fw && cfg_state && pstrb[0] |-> ##2
    fifo_buf_count == fmap($past(pwdata[5:0], 2))) else $error("fifo count wrong");
  chk_fifo_cap: assert property (fifo_buf_count <= 6'h3B) else $error("fifo count too big");
  chk_refused_pulse: assert property (fw && !cfg_state |=> fifo_write_refused)
    else $error("refused write not flagged");
  chk_refused_keep: assert property (fw && !cfg_state |=> $stable(fifo_buf_count)[*2])
    else $error("refused write changed fifo");
  // receive frame id flags and buffer words
  chk_rx_flags_load: assert property (rx_hdr.load |=>
    rx_frame_id[15:11] == $past(rx_hdr.flags)) else $error("rx flags not loaded");
  chk_rx_flags_hold: assert property (!rx_hdr.load |=> $stable(rx_frame_id[15:11]))
    else $error("rx flags moved");
  chk_buf_range: assert property (core_buf_idx > 6'h3A |=> core_buf_word == 16'h0000)
    else $error("word beyond last buffer");
endmodule : mfc_regs_checker
bind mfc_regs mfc_regs_checker mfc_regs_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cfg_state(cfg_state), .rx_hdr(rx_hdr), .core_buf_idx(core_buf_idx),
  .core_buf_word(core_buf_word), .rx_frame_id(rx_frame_id),
  .fifo_buf_count(fifo_buf_count), .fifo_write_refused(fifo_write_refused));
`default_nettype wire

// ===== tb.sv
// Purpose: register bank testbench driven over APB
// Assumes: zero-wait slave, 16-bit words in the low half
// Notes: byte address is four times the register index
`timescale 1ns/10ps
`default_nettype none
module tb;
  import mfc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic cfg_state, tx_status_load, tx_conflict, flag_set, fifo_write_refused;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, core_word_idx;
  logic [5:0] flag_idx, core_buf_idx, fifo_buf_count;
  logic [15:0] tx_frame_id, rx_frame_id, core_word_data, core_buf_word, rd;
  logic [6:0] tx_payload_len;
  logic [10:0] tx_header_crc;
  mfc_rx_hdr_t rx_hdr;
  int n_errors, checks_done;
  logic [15:0] fc [5] = '{16'h0000, 16'h0001, 16'h003A, 16'h003B, 16'hFFFF};
  logic [15:0] fn [5] = '{16'h0000, 16'h0001, 16'h003A, 16'h003B, 16'h003B};

  mfc_regs mfc_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_state(cfg_state), .rx_hdr(rx_hdr),
    .tx_status_load(tx_status_load), .tx_conflict(tx_conflict), .flag_set(flag_set),
    .flag_idx(flag_idx), .core_word_idx(core_word_idx), .core_buf_idx(core_buf_idx),
    .fifo_buf_count(fifo_buf_count), .tx_frame_id(tx_frame_id),
    .tx_payload_len(tx_payload_len), .tx_header_crc(tx_header_crc),
    .rx_frame_id(rx_frame_id), .core_word_data(core_word_data),
    .core_buf_word(core_buf_word), .fifo_write_refused(fifo_write_refused));

  // verdict and end of run
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // one APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
      input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready === 1'b1) begin
      rd = prdata[15:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end else begin
      n_errors++; // a missing ready counts as a mismatch
      report_and_stop();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000, 4'h0);
    cmp(rd, exp);
  endtask : rchk

  task automatic step(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : step

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'h0; cfg_state = 1'b1; rx_hdr = '0; tx_status_load = 1'b0;
    tx_conflict = 1'b0; flag_set = 1'b0; flag_idx = 6'h00; core_word_idx = 4'h0;
    core_buf_idx = 6'h00; n_errors = 0; checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values
    rchk(12'h060, 16'h0000);
    rchk(12'h800, 16'h0000);
    rchk(12'hBA0, 16'h0000);
    // every size code class, including saturation; accepted writes never flag
    for (int k = 0; k < 5; k++) begin
      wr(12'h060, fc[k]);
      #1;
      cmp({15'h0000, fifo_write_refused}, 16'h0000);
      step(2);
      cmp({10'h000, fifo_buf_count}, fn[k]);
      rchk(12'h060, fc[k] & 16'h003F);
    end
    // size write outside configuration state is dropped and flagged
    cfg_state <= 1'b0;
    wr(12'h060, 16'h0005);
    #1;
    cmp({15'h0000, fifo_write_refused}, 16'h0001);
    step(2);
    cmp({10'h000, fifo_buf_count}, 16'h003B);
    rchk(12'h060, 16'h003F);
    cfg_state <= 1'b1;
    // buffer control words, first and last
    wr(12'h800, 16'hFFFF);
    rchk(12'h800, 16'hFF4D);
    wr(12'hBA0, 16'h1234);
    rchk(12'hBA0, 16'h1204);
    // core strobes in one cycle
    @(posedge pclk);
    flag_idx <= 6'h03;
    flag_set <= 1'b1;
    tx_conflict <= 1'b1;
    tx_status_load <= 1'b1;
    rx_hdr <= {1'b1, 5'h15};
    @(posedge pclk);
    flag_set <= 1'b0;
    tx_status_load <= 1'b0;
    rx_hdr <= '0;
    rchk(12'h830, 16'h0004);
    core_buf_idx <= 6'h3A;
    step(2);
    cmp(core_buf_word, 16'h1204);
    core_buf_idx <= 6'h3B;
    step(2);
    cmp(core_buf_word, 16'h0000);
    // payload words and byte lanes
    wr(12'h618, 16'hA1B2);
    wr(12'h690, 16'h5566);
    apb(1'b1, 12'h618, 16'hFFCC, 4'h1);
    rchk(12'h618, 16'hA1CC);
    rchk(12'h690, 16'h5566);
    core_word_idx <= 4'hF;
    step(2);
    cmp(core_word_data, 16'h5566);
    // transmit header words
    wr(12'h608, 16'hFFFF);
    rchk(12'h608, 16'h007F);
    cmp({9'h000, tx_payload_len}, 16'h007F);
    wr(12'h610, 16'hFFFF);
    rchk(12'h610, 16'h07FF);
    cmp({5'h00, tx_header_crc}, 16'h07FF);
    wr(12'h600, 16'hFFFF);
    rchk(12'h600, 16'hC7FF);
    cmp(tx_frame_id, 16'hC7FF);
    // status: conflict bit loaded, host write ignored
    wr(12'h698, 16'hFFFE);
    rchk(12'h698, 16'h0001);
    // receive frame id: id bits follow the host, hardware flags stay
    wr(12'h500, 16'hFFFF);
    rchk(12'h500, 16'hAFFF);
    wr(12'h500, 16'h0000);
    rchk(12'h500, 16'hA800);
    // unmapped address
    apb(1'b0, 12'h004, 16'h0000, 4'h0);
    cmp({15'h0000, er}, 16'h0001);
    cmp(rd, 16'h0000);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
